// file: verilog/ssp_defines.vh
// constants for the secondary serial port control block
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH
// register byte addresses
`define SSP_ADDR_TXCTL   4'h0
`define SSP_ADDR_RXCTL   4'h4
`define SSP_ADDR_DATA    4'h8
`define SSP_ADDR_BAUD    4'hC
// transmit control/status fields
`define SSP_TX_CLOCK_SOURCE_SELECT      7
`define SSP_TX_TX9       6
`define SSP_TX_EN        5
`define SSP_TX_SYNC      4
`define SSP_TX_HIGH      2
`define SSP_TX_EMPTY     1
`define SSP_TX_NINTH     0
// receive control/status fields
`define SSP_RX_PEN       7
`define SSP_RX_RX9       6
`define SSP_RX_SINGLE    5
`define SSP_RX_CONT      4
`define SSP_RX_ADDR      3
`define SSP_RX_FRAMING_ERROR_FLAG      2
`define SSP_RX_OVERRUN_ERROR_FLAG      1
`define SSP_RX_NINTH     0
// writable masks and reset values
`define SSP_TXCTL_WMASK  8'hF5
`define SSP_RXCTL_WMASK  8'hF8
`define SSP_TXCTL_RESET  8'h02
`define SSP_RXCTL_RESET  8'h00
`define SSP_BAUD_RESET   8'h00
// baud divisors: async low, async high, sync
`define SSP_DIV_LOW      7'd64
`define SSP_DIV_HIGH     7'd16
`define SSP_DIV_SYNC     7'd4
`endif

// file: verilog/ssp_baud.v
// baud generator: one-cycle tick every div*(n+1) clocks
`timescale 1ns/1ps
`default_nettype none
module ssp_baud (
  // clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // control
  input  wire       clear_i,
  input  wire [7:0] value_i,
  input  wire [6:0] div_i,
  // tick
  output reg        tick_o
);
  reg [14:0] cnt_q;
  wire [14:0] last_w;
  assign last_w = ({7'h00, value_i} + 15'd1) * {8'h00, div_i} - 15'd1;
  // free-running counter, cleared by a rate write
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_q  <= 15'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q >= last_w) begin
      cnt_q  <= 15'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 15'd1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verilog/ssp_top.v
// secondary serial port control: registers, tx and rx engines
// Notes on behaviour
// - port enable claims pins; clear holds the channel in reset
// - clock source: master uses baud generator, slave external clock
// - nine-bit transmit selects 9-bit frames, ninth bit from control
// - transmit enable; sync receive enables override it
// - mode bit selects synchronous or asynchronous operation
// - high-speed bit changes async baud rate only
// - shift-empty status reads 1 when shifter idle, resets to 1
// - nine-bit receive select chooses 9-bit reception
// - single receive takes one word in sync master, self-clears
// - continuous receive enables async rx, sync runs until cleared
// - async 9-bit address detect accepts only words with bit 8 set
// - framing flag follows current word, updates only when a new word is loaded
// - overrun flag set on overrun, cleared by clearing continuous rx
// - ninth received bit shown in receive status bit 0
// - open-drain control makes transmit pin drive low only
// - three modes: async full-duplex, sync master, sync slave
// - writing the baud value restarts the baud generator
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // port control
  input  wire        open_drain_i,
  // transmit/clock pin
  input  wire        tx_ck_i,
  output reg         tx_ck_o,
  output reg         tx_ck_oe_o,
  // receive/data pin
  input  wire        rx_dt_i,
  output reg         rx_dt_o,
  output reg         rx_dt_oe_o,
  // status
  output reg         rx_flag_o,
  output reg         tx_flag_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SHFT = 2'd1;
  localparam ST_STOP = 2'd2;

  reg  [7:0] txc_q;
  reg  [7:0] rxc_q;
  reg  [7:0] baud_q;
  reg  [7:0] txbuf_q;
  reg        txfull_q;
  reg  [8:0] rdat_q;
  reg  [8:0] tsr_q;
  reg  [3:0] tcnt_q;
  reg  [1:0] tst_q;
  reg  [3:0] tsub_q;
  reg  [8:0] rsr_q;
  reg  [3:0] rcnt_q;
  reg  [1:0] rst_q;
  reg  [3:0] rsub_q;
  reg        framing_error_flag_q;
  reg        overrun_error_flag_q;
  reg        fpend_q;
  reg        ckp_q;
  reg        sclk_q;
  reg        baud_clr_q;
  wire       req_w;
  wire       wr_w;
  wire       rd_w;
  wire       en_w;
  wire       sync_w;
  wire       mast_w;
  wire       rxon_w;
  wire       txok_w;
  wire       tick_w;
  wire       os_w;
  wire [3:0] nbits_t;
  wire [3:0] nbits_r;
  wire [6:0] div_w;
  wire       slv_fall;
  wire       slv_rise;
  wire       done_w;
  wire       tgo_w;

  // decode of bus request and mode
  assign req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_w    = req_w & wb_we_i & wb_sel_i[0];
  assign rd_w    = req_w & ~wb_we_i;
  assign en_w    = rxc_q[`SSP_RX_PEN];
  assign sync_w  = txc_q[`SSP_TX_SYNC];
  assign mast_w  = sync_w & txc_q[`SSP_TX_CLOCK_SOURCE_SELECT];
  assign rxon_w  = rxc_q[`SSP_RX_CONT] |
                   (mast_w & rxc_q[`SSP_RX_SINGLE]);
  assign txok_w  = txc_q[`SSP_TX_EN] & ~(sync_w & rxon_w);
  assign nbits_t = txc_q[`SSP_TX_TX9] ? 4'd9 : 4'd8;
  assign nbits_r = rxc_q[`SSP_RX_RX9] ? 4'd9 : 4'd8;
  assign div_w   = sync_w ? `SSP_DIV_SYNC :
                   (txc_q[`SSP_TX_HIGH] ? `SSP_DIV_HIGH
                                        : `SSP_DIV_LOW);
  assign os_w    = tick_w;
  // async frames start on a tick so the start bit is one full bit time
  assign tgo_w   = txfull_q && txok_w && (sync_w || os_w);
  assign slv_fall = ckp_q & ~tx_ck_i;
  assign slv_rise = ~ckp_q & tx_ck_i;

  ////////////////////////////////////////////////////////////////////////
  // baud generator
  ssp_baud u_baud (
    .clk_i   (clk_i),
    .rst_i   (rst_i | ~en_w),
    .clear_i (baud_clr_q),
    .value_i (baud_q),
    .div_i   (div_w),
    .tick_o  (tick_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // wishbone registers, one cycle to ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
      txc_q      <= `SSP_TXCTL_RESET;
      rxc_q      <= `SSP_RXCTL_RESET;
      baud_q     <= `SSP_BAUD_RESET;
      txbuf_q    <= 8'h00;
      txfull_q   <= 1'b0;
      baud_clr_q <= 1'b0;
    end else begin
      wb_ack_o   <= req_w;
      baud_clr_q <= 1'b0;
      if (rd_w) begin
        case (wb_adr_i)
          `SSP_ADDR_TXCTL: wb_dat_o <= {24'h000000, txc_q[7:2],
                                        (tst_q == ST_IDLE),
                                        txc_q[0]};
          `SSP_ADDR_RXCTL: wb_dat_o <= {24'h000000, rxc_q[7:3],
                                        framing_error_flag_q, overrun_error_flag_q,
                                        rdat_q[8]};
          `SSP_ADDR_DATA:  wb_dat_o <= {24'h000000, rdat_q[7:0]};
          `SSP_ADDR_BAUD:  wb_dat_o <= {24'h000000, baud_q};
          default:         wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wr_w) begin
        case (wb_adr_i)
          `SSP_ADDR_TXCTL: txc_q <= (wb_dat_i[7:0] & `SSP_TXCTL_WMASK);
          `SSP_ADDR_RXCTL: rxc_q <= (wb_dat_i[7:0] & `SSP_RXCTL_WMASK);
          `SSP_ADDR_DATA: begin
            txbuf_q  <= wb_dat_i[7:0];
            txfull_q <= 1'b1;
          end
          `SSP_ADDR_BAUD: begin
            baud_q     <= wb_dat_i[7:0];
            baud_clr_q <= 1'b1;
          end
          default: ;
        endcase
      end
      if (tgo_w && tst_q == ST_IDLE && en_w)
        txfull_q <= 1'b0;
      if (done_w && mast_w && !rxc_q[`SSP_RX_CONT])
        rxc_q[`SSP_RX_SINGLE] <= 1'b0;
      if (!en_w) begin
        txfull_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync clock: master toggles on ticks, slave samples pin
  always @(posedge clk_i) begin
    if (rst_i || !en_w) begin
      sclk_q <= 1'b1;
      ckp_q  <= 1'b1;
    end else begin
      ckp_q <= tx_ck_i;
      if (mast_w && tick_w && (tst_q == ST_SHFT || rst_q == ST_SHFT))
        sclk_q <= ~sclk_q;
      else if (!(tst_q == ST_SHFT || rst_q == ST_SHFT))
        sclk_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter: async start/data/stop or sync data on data pin
  always @(posedge clk_i) begin
    if (rst_i || !en_w) begin
      tst_q  <= ST_IDLE;
      tsr_q  <= 9'h1FF;
      tcnt_q <= 4'h0;
      tsub_q <= 4'h0;
    end else begin
      case (tst_q)
        ST_IDLE: begin
          if (tgo_w) begin
            // in 8-bit frames bit 8 is the stop level
            tsr_q  <= {(txc_q[`SSP_TX_TX9] ? txc_q[`SSP_TX_NINTH]
                                           : 1'b1), txbuf_q};
            tcnt_q <= 4'h0;
            tsub_q <= 4'h0;
            tst_q  <= sync_w ? ST_SHFT : ST_STOP;
          end
        end
        ST_STOP: begin
          // async start bit held one bit period, then data
          if (os_w) begin
            tst_q <= ST_SHFT;
          end
        end
        ST_SHFT: begin
          if (sync_w ? (mast_w ? (tick_w && !sclk_q) : slv_fall)
                     : os_w) begin
            tsr_q  <= {1'b1, tsr_q[8:1]};
            tcnt_q <= tcnt_q + 4'd1;
            if (tcnt_q == nbits_t - 4'd1 + (sync_w ? 4'd0 : 4'd1))
              tst_q <= ST_IDLE;
          end
        end
        default: tst_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver: sample on free-running baud ticks (async) or clock edge (sync)
  assign done_w = (rst_q == ST_SHFT) && (rcnt_q == nbits_r) &&
                  (sync_w ? 1'b1 : os_w);
  always @(posedge clk_i) begin
    if (rst_i || !en_w) begin
      rst_q   <= ST_IDLE;
      rsr_q   <= 9'h000;
      rcnt_q  <= 4'h0;
      rsub_q  <= 4'h0;
      rdat_q  <= 9'h000;
      framing_error_flag_q  <= 1'b0;
      overrun_error_flag_q  <= 1'b0;
      fpend_q <= 1'b0;
      rx_flag_o <= 1'b0;
    end else begin
      if (rd_w && wb_adr_i == `SSP_ADDR_DATA)
        rx_flag_o <= 1'b0;
      if (!rxc_q[`SSP_RX_CONT])
        overrun_error_flag_q <= 1'b0;
      case (rst_q)
        ST_IDLE: begin
          rcnt_q <= 4'h0;
          if (rxon_w && (sync_w || !rx_dt_i))
            // a tick on the detect edge already sampled the start bit
            rst_q <= (sync_w || os_w) ? ST_SHFT : ST_STOP;
        end
        ST_STOP: begin
          if (os_w)
            rst_q <= rx_dt_i ? ST_IDLE : ST_SHFT;
        end
        ST_SHFT: begin
          if (rcnt_q != nbits_r &&
              (sync_w ? (mast_w ? (tick_w && !sclk_q) : slv_fall) : os_w)) begin
            rsr_q  <= {rx_dt_i, rsr_q[8:1]};
            rcnt_q <= rcnt_q + 4'd1;
          end
          if (!rxon_w)
            rst_q <= ST_IDLE;
          if (done_w) begin
            rst_q <= ST_IDLE;
            // skip data words when address detect is on in async 9-bit reception
            if (!(!sync_w && rxc_q[`SSP_RX_RX9] &&
                  rxc_q[`SSP_RX_ADDR] && !rsr_q[8])) begin
              if (overrun_error_flag_q) begin
              end else if (rx_flag_o) begin
                if (rxc_q[`SSP_RX_CONT] || !sync_w)
                  overrun_error_flag_q <= 1'b1;
              end else begin
                rdat_q <= rxc_q[`SSP_RX_RX9] ? rsr_q
                                             : {1'b0, rsr_q[8:1]};
                rx_flag_o <= 1'b1;
                framing_error_flag_q <= !sync_w && !rx_dt_i;
              end
            end
          end
        end
        default: rst_q <= ST_IDLE;
      endcase
      if (rx_flag_o && rd_w && wb_adr_i == `SSP_ADDR_DATA)
        fpend_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers and transmit flag
  always @(posedge clk_i) begin
    if (rst_i || !en_w) begin
      tx_ck_o    <= 1'b1;
      tx_ck_oe_o <= 1'b0;
      rx_dt_o    <= 1'b1;
      rx_dt_oe_o <= 1'b0;
      tx_flag_o  <= 1'b0;
    end else begin
      tx_flag_o <= ~txfull_q;
      if (!sync_w) begin
        // async: tx pin is data out, rx pin input
        tx_ck_o    <= (tst_q == ST_STOP) ? 1'b0 :
                      (tst_q == ST_SHFT) ? tsr_q[0] : 1'b1;
        tx_ck_oe_o <= open_drain_i ?
                      ~((tst_q == ST_STOP) ? 1'b0 :
                        (tst_q == ST_SHFT) ? tsr_q[0] : 1'b1)
                      : 1'b1;
        rx_dt_oe_o <= 1'b0;
      end else begin
        // sync: master drives clock; data out only while sending
        tx_ck_o    <= sclk_q;
        tx_ck_oe_o <= mast_w & (~open_drain_i | ~sclk_q);
        rx_dt_o    <= tsr_q[0];
        rx_dt_oe_o <= (tst_q == ST_SHFT) & ~rxon_w;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/ssp_partner.sv
// far-side serial device: async sender, async sampler, sync data level
`timescale 1ns/1ps
`default_nettype none
module ssp_partner (
  // clock
  input  wire logic clk_i,
  // level seen on the block's transmit/clock pin
  input  wire logic tx_i,
  // level driven onto the block's receive/data pin
  output logic      dt_o = 1'b1
);
  // one async frame: start, n bits lsb first, stop, then idle mark
  task send(input logic [8:0] w, input int n, input logic stp, input int bt);
    @(posedge clk_i);
    dt_o <= 1'b0;
    repeat (bt) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      dt_o <= w[i];
      repeat (bt) @(posedge clk_i);
    end
    dt_o <= stp;
    repeat (bt) @(posedge clk_i);
    dt_o <= 1'b1;
    repeat (bt) @(posedge clk_i);
  endtask
  // steady data level for sync reception
  task level(input logic v);
    @(posedge clk_i);
    dt_o <= v;
  endtask
  // sample one async frame in mid-bit, stop bit returned in s
  task recv(input int n, input int bt, output logic [8:0] w, output logic s);
    w = 9'h000;
    while (tx_i !== 1'b0) @(posedge clk_i);
    repeat (bt / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (bt) @(posedge clk_i);
      w[i] = tx_i;
    end
    repeat (bt) @(posedge clk_i);
    s = tx_i;
  endtask
endmodule
`default_nettype wire

// file: sim/ssp_top_assertions.sv
// port-level assertions for the secondary serial port control
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_top_assertions (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and status
  input wire logic        open_drain_i,
  input wire logic        tx_ck_o,
  input wire logic        tx_ck_oe_o,
  input wire logic        rx_dt_oe_o,
  input wire logic        rx_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic en_q;
  // shadow of the port enable bit, taken on an acked write
  always @(posedge clk_i) begin
    if (rst_i)
      en_q <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] &&
             wb_adr_i == `SSP_ADDR_RXCTL)
      en_q <= wb_dat_i[`SSP_RX_PEN];
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  a_reset_pins: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && tx_ck_o && !tx_ck_oe_o && !rx_dt_oe_o && !rx_flag_o)
    else $error("outputs not idle in reset");
  a_pins_released: assert property (!en_q && !$past(en_q) |->
    !tx_ck_oe_o && !rx_dt_oe_o)
    else $error("pin driven while port disabled");
  a_open_drain: assert property (open_drain_i && $past(open_drain_i) &&
    tx_ck_oe_o |-> !tx_ck_o)
    else $error("open-drain pin driven high");
  a_read_clears: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == `SSP_ADDR_DATA |=> !rx_flag_o)
    else $error("receive flag kept after data read");
endmodule
bind ssp_top ssp_top_assertions chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .open_drain_i(open_drain_i), .tx_ck_o(tx_ck_o), .tx_ck_oe_o(tx_ck_oe_o),
  .rx_dt_oe_o(rx_dt_oe_o), .rx_flag_o(rx_flag_o)
);
`default_nettype wire

// file: sim/ssp_top_bench.sv
// self-checking bench for the secondary serial port control
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defines.vh"
module ssp_top_bench;
  localparam logic [3:0] ad_tx = `SSP_ADDR_TXCTL;
  localparam logic [3:0] ad_rx = `SSP_ADDR_RXCTL;
  localparam logic [3:0] ad_dt = `SSP_ADDR_DATA;
  logic        clk_i = 1'b0, rst_i = 1'b1, open_drain_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, tx_ck_o, tx_ck_oe_o, rx_dt_o, rx_dt_oe_o;
  logic        rx_flag_o, tx_flag_o, p_dt, tx_ck_i, rx_dt_i;
  int          fail_count = 0, checked = 0, cyc_n = 0;
  // pin levels: pull-up on the clock pin, partner drives data when released
  assign tx_ck_i = tx_ck_oe_o ? tx_ck_o : 1'b1;
  assign rx_dt_i = rx_dt_oe_o ? rx_dt_o : p_dt;
  ssp_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .open_drain_i(open_drain_i), .tx_ck_i(tx_ck_i), .tx_ck_o(tx_ck_o),
    .tx_ck_oe_o(tx_ck_oe_o), .rx_dt_i(rx_dt_i), .rx_dt_o(rx_dt_o),
    .rx_dt_oe_o(rx_dt_oe_o), .rx_flag_o(rx_flag_o), .tx_flag_o(tx_flag_o)
  );
  ssp_partner p_u (.clk_i(clk_i), .tx_i(tx_ck_i), .dt_o(p_dt));
  // clock and run limit
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      fail_count++;
      finish_test;
    end
  end
  task chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d,
          output logic [7:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] r;
    wb(1'b0, a, 8'h00, r);
    chk(r, exp);
  endtask
  task wait_flag;
    for (int i = 0; i < 3000 && rx_flag_o !== 1'b1; i++) @(posedge clk_i);
    chk(rx_flag_o, 1'b1);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task t_regs;
    logic [7:0] r;
    rd(ad_tx, 8'h02);
    rd(ad_rx, 8'h00);
    wb(1'b1, ad_tx, 8'hFF, r);
    rd(ad_tx, 8'hF7);
    @(posedge clk_i);
    wb_sel_i <= 4'hE;
    wb(1'b1, ad_tx, 8'h00, r);
    wb_sel_i <= 4'hF;
    rd(ad_tx, 8'hF7);
    wb(1'b1, 4'h2, 8'h5A, r);
    rd(4'h2, 8'h00);
    wb(1'b1, ad_tx, 8'h00, r);
  endtask
  task t_tx;
    logic [7:0] r;
    logic [8:0] w;
    logic       s;
    wb(1'b1, `SSP_ADDR_BAUD, 8'h00, r);
    wb(1'b1, ad_rx, 8'h80, r);
    wb(1'b1, ad_tx, 8'h24, r);
    wb(1'b1, ad_dt, 8'hA5, r);
    fork
      p_u.recv(8, 16, w, s);
      begin
        repeat (20) @(posedge clk_i);
        rd(ad_tx, 8'h24);
      end
    join
    chk(w, 9'h0A5);
    chk(s, 1'b1);
    repeat (16) @(posedge clk_i);
    rd(ad_tx, 8'h26);
    chk(tx_flag_o, 1'b1);
    open_drain_i <= 1'b1;
    wb(1'b1, ad_tx, 8'h65, r);
    wb(1'b1, ad_dt, 8'h3C, r);
    p_u.recv(9, 16, w, s);
    chk(w, 9'h13C);
    repeat (16) @(posedge clk_i);
    open_drain_i <= 1'b0;
    wb(1'b1, ad_tx, 8'h20, r);
    wb(1'b1, ad_dt, 8'h96, r);
    p_u.recv(8, 64, w, s);
    chk(w, 9'h096);
    repeat (64) @(posedge clk_i);
  endtask
  task t_rx;
    logic [7:0] r;
    wb(1'b1, ad_tx, 8'h04, r);
    wb(1'b1, ad_rx, 8'h90, r);
    p_u.send(9'h05A, 8, 1'b1, 16);
    wait_flag;
    rd(ad_rx, 8'h90);
    rd(ad_dt, 8'h5A);
    p_u.send(9'h0C3, 8, 1'b0, 16);
    wait_flag;
    rd(ad_rx, 8'h94);
    rd(ad_dt, 8'hC3);
    p_u.send(9'h011, 8, 1'b1, 16);
    wait_flag;
    rd(ad_rx, 8'h90);
    rd(ad_dt, 8'h11);
    p_u.send(9'h021, 8, 1'b1, 16);
    p_u.send(9'h022, 8, 1'b1, 16);
    rd(ad_rx, 8'h92);
    rd(ad_dt, 8'h21);
    p_u.send(9'h023, 8, 1'b1, 16);
    chk(rx_flag_o, 1'b0);
    wb(1'b1, ad_rx, 8'h80, r);
    rd(ad_rx, 8'h80);
    p_u.send(9'h044, 8, 1'b1, 16);
    chk(rx_flag_o, 1'b0);
    wb(1'b1, ad_rx, 8'hD8, r);
    p_u.send(9'h055, 9, 1'b1, 16);
    chk(rx_flag_o, 1'b0);
    p_u.send(9'h1AB, 9, 1'b1, 16);
    wait_flag;
    rd(ad_rx, 8'hD9);
    rd(ad_dt, 8'hAB);
  endtask
  task t_sync;
    logic [7:0] r;
    wb(1'b1, ad_rx, 8'h00, r);
    wb(1'b1, ad_tx, 8'h90, r);
    p_u.level(1'b0);
    wb(1'b1, ad_rx, 8'hA0, r);
    repeat (4) @(posedge clk_i);
    chk(tx_ck_oe_o, 1'b1);
    wait_flag;
    rd(ad_rx, 8'h80);
    rd(ad_dt, 8'h00);
    p_u.level(1'b1);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ad_rx, 8'h00);
    chk(tx_ck_oe_o, 1'b0);
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_sync;
    finish_test;
  end
endmodule
`default_nettype wire
